/* spi_diag_slave_port.sv */
// SPI slave port with in-frame response, global fault summary and protocol error checks
//
// Function
// - Receive a 16-bit control word serially on the data input, clocked by the master.
// - Shift the addressed register's contents out within the same frame.
// - A frame begins at chip select low and lasts while it stays low.
// - Decode and execute the received word only after chip select rises.
// - Release the serial output to high impedance when chip select rises.
// - Capture the data input on every falling serial clock edge.
// - Shift the next output bit on every rising serial clock edge.
// - Write, clear and read registers only as whole bytes.
// - Never clear configuration or status bits without a master command.
// - Ignore frames until the set time after the enable pin rises.
// - Before the first rising clock, drive output as fault flag OR data input.
// - Set the fault flag on any fault and after power-on reset.
// - Accept zero-clock frames without flagging a protocol error.
// - Shift out the global fault summary byte during the first eight clocks.
// - Fault flag is OR of summary faults and the inverted reset-seen bit.
// - Load fault bit is OR of all open load and overcurrent flags.
// - Reset-seen bit reads 0 after reset, so the fault flag reads 1.
// - Protocol error is summary bit 7, reported in the following frame.
// - Error when the clock count is neither 0 nor a multiple of 8 from 16 to 120.
// - Error when a command targets an unused register address.
// - Error when the address byte's least significant bit is not 1.
// - Error when the last-address token, address bit 1, is not 1.
// - Error when the serial clock is high at either chip select edge.
// - Address bit 7 selects read only, or write / read-and-clear.
// - Address bits 6..2 select the register; data byte LSB set by master.
// - Ignore a clear request if a new fault hits that status register mid-frame.
`timescale 1ns/10ps
`default_nettype none
`include "sdsp_params.svh"

module spi_diag_slave_port (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic sdi,
	input wire logic enable,
	input wire sdsp_pkg::sdsp_fault_ev_t fault_ev,
	output logic sdo,
	output logic sdo_oe,
	output sdsp_pkg::sdsp_ctrl_wr_t ctrl_wr,
	output sdsp_pkg::sdsp_gstat_t gstat
);
	import sdsp_pkg::*;

	localparam int SET_CYCLES = (`SDSP_SET_TIME_NS + `SDSP_CLK_PERIOD_NS - 1) / `SDSP_CLK_PERIOD_NS;

	// Synchronisers: stage 1 feeds stage 2 only, stage 3 is for edge detection
	logic [3:0] s1_ff, s2_ff, s3_ff;
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			{s3_ff, s2_ff, s1_ff} <= 12'haaa; // Idle levels, clock low, so no false edge after reset
		else
			{s3_ff, s2_ff, s1_ff} <= {s2_ff, s1_ff, enable, sdi, chip_select_n, sclk};
	end

	logic sclk_s, cs_n_s, sdi_s, en_s, sclk_rise, sclk_fall, cs_fall, cs_rise;
	assign sclk_s = s2_ff[0];
	assign cs_n_s = s2_ff[1];
	assign sdi_s = s2_ff[2];
	assign en_s = s2_ff[3];
	assign sclk_rise = sclk_s & ~s3_ff[0];
	assign sclk_fall = ~sclk_s & s3_ff[0];
	assign cs_fall = ~cs_n_s & s3_ff[1];
	assign cs_rise = cs_n_s & ~s3_ff[1];

	// Frame state
	sdsp_state_t state_ff, nxt_state;
	logic [`SDSP_WAIT_W-1:0] wait_ff, nxt_wait;
	logic [`SDSP_CNT_W-1:0] nfall_ff, nxt_nfall, nrise_ff, nxt_nrise;
	logic [15:0] in_sr_ff, nxt_in_sr;
	logic [7:0] addr_ff, nxt_addr, snap_ff, nxt_snap;
	logic pol_err_ff, nxt_pol_err, sdo_ff, nxt_sdo, sdo_oe_ff, nxt_sdo_oe;
	logic [2:0] new_ff, nxt_new;

	// Status and control storage
	sdsp_gstat_t gstat_ff, nxt_gstat;
	logic [7:0] ol_ff, nxt_ol, oc_ff, nxt_oc;
	sdsp_ctrl_wr_t wr_ff, nxt_wr;
	logic [7:0] mem_rd;

	// Decode of the captured address byte
	logic [4:0] reg_idx;
	logic is_ctrl, is_stat, addr_bad, count_bad, frame_err, frame_ok, exec;
	logic any_fault_flag, clr_gst, clr_ol, clr_oc, out_bit;
	logic [7:0] resp;
	assign reg_idx = addr_ff[`SDSP_ADDR_REG_HI:`SDSP_ADDR_REG_LO];
	assign is_ctrl = reg_idx < `SDSP_CTRL_COUNT;
	assign is_stat = (reg_idx == `SDSP_REG_GSTAT) || (reg_idx == `SDSP_REG_OPEN_LOAD)
		|| (reg_idx == `SDSP_REG_OVER_CURRENT);
	// Unused address, stuck-low LSB and missing token all count as one error
	assign addr_bad = (!is_ctrl && !is_stat)
		|| !addr_ff[`SDSP_ADDR_LSB_BIT]
		|| !addr_ff[`SDSP_ADDR_TOKEN_BIT];
	assign count_bad = (nfall_ff != 7'h00)
		&& ((nfall_ff < `SDSP_FRAME_BITS) || (nfall_ff[2:0] != 3'h0) || (nfall_ff == `SDSP_CNT_MAX));
	assign frame_err = cs_rise && (state_ff == SDSP_ST_FRAME) && (pol_err_ff || sclk_s || count_bad
		|| ((nfall_ff >= `SDSP_BYTE_BITS) && addr_bad));
	// Only an exact two-byte frame is executed, so partial bytes never act
	assign frame_ok = cs_rise && !frame_err && (nfall_ff == `SDSP_FRAME_BITS);
	assign exec = (state_ff == SDSP_ST_FRAME) && en_s && frame_ok && addr_ff[`SDSP_ADDR_OP_BIT];
	// A fault that lands in the target during the frame cancels the clear
	assign clr_gst = exec && (reg_idx == `SDSP_REG_GSTAT) && !new_ff[0];
	assign clr_ol = exec && (reg_idx == `SDSP_REG_OPEN_LOAD) && !new_ff[1];
	assign clr_oc = exec && (reg_idx == `SDSP_REG_OVER_CURRENT) && !new_ff[2];

	// Fault flag: every summary fault plus the inverted reset-seen bit
	assign any_fault_flag = gstat_ff.spi_err_bit | gstat_ff.load_fault_bit | gstat_ff.supply_low_bit
		| gstat_ff.supply_high_bit | ~gstat_ff.reset_seen_n_bit | gstat_ff.thermal_shutdown_bit
		| gstat_ff.thermal_prewarning_bit;

	// In-frame response: live contents, so a mid-frame fault shows in the data byte
	always_comb
	begin
		resp = mem_rd;
		if (reg_idx == `SDSP_REG_GSTAT)
			resp = gstat_ff;
		else if (reg_idx == `SDSP_REG_OPEN_LOAD)
			resp = ol_ff;
		else if (reg_idx == `SDSP_REG_OVER_CURRENT)
			resp = oc_ff;
		else if (!is_ctrl)
			resp = 8'h00;
	end

	// Bit order is LSB first: summary byte, then the response byte
	always_comb
	begin
		out_bit = 1'b0;
		if (nrise_ff < `SDSP_BYTE_BITS)
			out_bit = snap_ff[nrise_ff[2:0]];
		else if (nrise_ff < `SDSP_FRAME_BITS)
			out_bit = resp[nrise_ff[2:0]];
	end

	// Frame sequencer
	always_comb
	begin
		nxt_state = state_ff;
		nxt_wait = wait_ff;
		nxt_nfall = nfall_ff;
		nxt_nrise = nrise_ff;
		nxt_in_sr = in_sr_ff;
		nxt_addr = addr_ff;
		nxt_snap = snap_ff;
		nxt_pol_err = pol_err_ff;
		nxt_sdo = sdo_ff;
		nxt_sdo_oe = sdo_oe_ff;
		nxt_new = new_ff;
		unique case (state_ff)
			SDSP_ST_WAIT:
			begin
				nxt_sdo_oe = 1'b0;
				if (!en_s)
					nxt_wait = '0;
				else if (wait_ff >= (`SDSP_WAIT_W)'(SET_CYCLES - 1))
					nxt_state = SDSP_ST_IDLE;
				else
					nxt_wait = wait_ff + 1'b1;
			end
			SDSP_ST_IDLE:
			begin
				if (!en_s)
				begin
					nxt_state = SDSP_ST_WAIT;
					nxt_wait = '0;
				end
				else if (cs_fall)
				begin
					nxt_state = SDSP_ST_FRAME;
					nxt_nfall = '0;
					nxt_nrise = '0;
					nxt_pol_err = sclk_s;
					nxt_snap = gstat_ff;
					nxt_new = 3'h0;
					nxt_sdo_oe = 1'b1;
					nxt_sdo = any_fault_flag | sdi_s;
				end
			end
			SDSP_ST_FRAME:
			begin
				// New faults per status target, for the clear guard
				nxt_new = new_ff | {|fault_ev.over_current, |fault_ev.open_load,
					|{fault_ev.open_load, fault_ev.over_current, fault_ev.supply_low,
					fault_ev.supply_high, fault_ev.thermal_shutdown, fault_ev.thermal_prewarning}};
				if (cs_rise || !en_s)
				begin
					nxt_state = en_s ? SDSP_ST_IDLE : SDSP_ST_WAIT;
					nxt_wait = '0;
					nxt_sdo_oe = 1'b0;
					nxt_sdo = 1'b0;
				end
				else if (sclk_fall)
				begin
					nxt_in_sr = {sdi_s, in_sr_ff[15:1]};
					if (nfall_ff != `SDSP_CNT_MAX)
						nxt_nfall = nfall_ff + 1'b1;
				end
				else if (sclk_rise)
				begin
					nxt_sdo = out_bit;
					if (nrise_ff != `SDSP_CNT_MAX)
						nxt_nrise = nrise_ff + 1'b1;
				end
				else if (nrise_ff == '0)
					nxt_sdo = any_fault_flag | sdi_s;
				// Address byte is complete after the eighth falling edge
				if (!sclk_fall && (nfall_ff == `SDSP_BYTE_BITS))
					nxt_addr = in_sr_ff[15:8];
			end
			default:
			begin
				nxt_state = SDSP_ST_WAIT;
				nxt_sdo_oe = 1'b0;
			end
		endcase
	end

	// Status bits: the event sets, only a master clear resets, and set wins
	always_comb
	begin
		nxt_ol = (clr_ol ? 8'h00 : ol_ff) | fault_ev.open_load;
		nxt_oc = (clr_oc ? 8'h00 : oc_ff) | fault_ev.over_current;
		nxt_gstat = clr_gst ? `SDSP_GSTAT_RESET : gstat_ff;
		nxt_gstat.reset_seen_n_bit = gstat_ff.reset_seen_n_bit | clr_gst;
		nxt_gstat.spi_err_bit = nxt_gstat.spi_err_bit | frame_err;
		nxt_gstat.supply_low_bit = nxt_gstat.supply_low_bit | fault_ev.supply_low;
		nxt_gstat.supply_high_bit = nxt_gstat.supply_high_bit | fault_ev.supply_high;
		nxt_gstat.thermal_shutdown_bit = nxt_gstat.thermal_shutdown_bit | fault_ev.thermal_shutdown;
		nxt_gstat.thermal_prewarning_bit = nxt_gstat.thermal_prewarning_bit | fault_ev.thermal_prewarning;
		nxt_gstat.load_fault_bit = |{nxt_ol, nxt_oc};
		nxt_gstat.spare_bit = 1'b0;
		nxt_wr.valid = exec && is_ctrl;
		nxt_wr.addr = reg_idx[3:0];
		nxt_wr.data = in_sr_ff[15:8];
	end

	// Register stage for sequencer, status and outputs
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_ff <= SDSP_ST_WAIT;
			wait_ff <= '0;
			nfall_ff <= '0;
			nrise_ff <= '0;
			in_sr_ff <= 16'h0000;
			addr_ff <= 8'h00;
			snap_ff <= `SDSP_GSTAT_RESET;
			pol_err_ff <= 1'b0;
			sdo_ff <= 1'b0;
			sdo_oe_ff <= 1'b0;
			new_ff <= 3'h0;
			gstat_ff <= `SDSP_GSTAT_RESET;
			ol_ff <= 8'h00;
			oc_ff <= 8'h00;
			wr_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			wait_ff <= nxt_wait;
			nfall_ff <= nxt_nfall;
			nrise_ff <= nxt_nrise;
			in_sr_ff <= nxt_in_sr;
			addr_ff <= nxt_addr;
			snap_ff <= nxt_snap;
			pol_err_ff <= nxt_pol_err;
			sdo_ff <= nxt_sdo;
			sdo_oe_ff <= nxt_sdo_oe;
			new_ff <= nxt_new;
			gstat_ff <= nxt_gstat;
			ol_ff <= nxt_ol;
			oc_ff <= nxt_oc;
			wr_ff <= nxt_wr;
		end
	end

	// Control registers; read data lag one cycle, well inside half an SPI clock
	sdsp_ctrl_mem u_ctrl_mem (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.wr_en(nxt_wr.valid),
		.wr_addr(reg_idx[3:0]),
		.wr_data(in_sr_ff[15:8]),
		.rd_addr(reg_idx[3:0]),
		.rd_data_ff(mem_rd)
	);

	assign sdo = sdo_ff;
	assign sdo_oe = sdo_oe_ff;
	assign ctrl_wr = wr_ff;
	assign gstat = gstat_ff;

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence frame_open_s;
		(state_ff == SDSP_ST_IDLE) && en_s && cs_fall;
	endsequence
	sequence frame_close_s;
		(state_ff == SDSP_ST_FRAME) && cs_rise;
	endsequence
	sdo_release_a: assert property (frame_close_s |=> !sdo_oe_ff && (state_ff != SDSP_ST_FRAME))
		else $error("serial output not released at chip select rise");
	frame_open_a: assert property (frame_open_s
		|=> sdo_oe_ff && (sdo_ff == ($past(any_fault_flag) | $past(sdi_s))))
		else $error("early output is not fault flag OR data input");
	wait_gate_a: assert property ((state_ff == SDSP_ST_WAIT) |-> !sdo_oe_ff && !wr_ff.valid)
		else $error("frame served before set time elapsed");
	err_next_frame_a: assert property (frame_close_s and (nfall_ff == 7'h08) |=> gstat_ff.spi_err_bit)
		else $error("bad clock count not flagged");
	zero_clock_a: assert property (frame_close_s and (nfall_ff == 7'h00) and !pol_err_ff and !sclk_s
		|=> $stable(gstat_ff.spi_err_bit))
		else $error("zero clock frame flagged as error");
	no_self_clear_a: assert property ($fell(gstat_ff.thermal_shutdown_bit) |-> $past(clr_gst))
		else $error("status bit cleared without a command");
	reset_flag_a: assert property (frame_open_s and !gstat_ff.reset_seen_n_bit |=> sdo_ff)
		else $error("frame start shows no fault flag while reset not acknowledged");
	load_or_a: assert property ((|{ol_ff, oc_ff}) |-> gstat_ff.load_fault_bit)
		else $error("load fault bit misses a channel flag");
	capture_fall_a: assert property ((state_ff == SDSP_ST_FRAME) && sclk_fall && !cs_rise && en_s
		|=> in_sr_ff[15] == $past(sdi_s))
		else $error("data input not captured at falling clock");
	summary_out_a: assert property ((state_ff == SDSP_ST_FRAME) && sclk_rise && !cs_rise
		&& en_s && (nrise_ff == 7'h07) |=> sdo_ff == snap_ff[7])
		else $error("summary bit 7 not shifted on eighth rising edge");
	write_whole_a: assert property (wr_ff.valid |-> $past(nfall_ff) == 7'h10)
		else $error("write executed on partial frame");
	keep_fault_a: assert property (exec && (reg_idx == `SDSP_REG_OPEN_LOAD) && new_ff[1] |=> ol_ff != 8'h00)
		else $error("clear wiped a fault raised during the frame");
endmodule // spi_diag_slave_port
`default_nettype wire

/* sdsp_params.svh */
// Offsets, field positions, reset values and timing counts of the diagnostic SPI slave port
`ifndef SDSP_PARAMS_SVH
`define SDSP_PARAMS_SVH

// Clock and timing
`define SDSP_CLK_PERIOD_NS 10
`define SDSP_SET_TIME_NS 10000
`define SDSP_WAIT_W 12

// Frame geometry
`define SDSP_CNT_W 7
`define SDSP_CNT_MAX 7'h7f
`define SDSP_BYTE_BITS 7'h08
`define SDSP_FRAME_BITS 7'h10

// Address byte fields
`define SDSP_ADDR_OP_BIT 7
`define SDSP_ADDR_REG_HI 6
`define SDSP_ADDR_REG_LO 2
`define SDSP_ADDR_TOKEN_BIT 1
`define SDSP_ADDR_LSB_BIT 0

// Register map, register index in address bits 6..2
`define SDSP_CTRL_COUNT 5'h0c
`define SDSP_REG_GSTAT 5'h10
`define SDSP_REG_OPEN_LOAD 5'h11
`define SDSP_REG_OVER_CURRENT 5'h12

// Global status reset value: all bits low, including the negated-reset bit
`define SDSP_GSTAT_RESET 8'h00
`define SDSP_CTRL_RESET 8'h00

`endif

/* sdsp_pkg.sv */
// Types of the diagnostic SPI slave port
package sdsp_pkg;

	// Frame sequencer states
	typedef enum logic [2:0] {
		SDSP_ST_WAIT = 3'b001,
		SDSP_ST_IDLE = 3'b010,
		SDSP_ST_FRAME = 3'b100
	} sdsp_state_t;

	// Global fault summary byte, bit 7 down to bit 0
	typedef struct packed {
		logic spi_err_bit;
		logic load_fault_bit;
		logic supply_low_bit;
		logic supply_high_bit;
		logic reset_seen_n_bit;
		logic thermal_shutdown_bit;
		logic thermal_prewarning_bit;
		logic spare_bit;
	} sdsp_gstat_t;

	// Fault events from the power stage, same clock domain
	typedef struct packed {
		logic [7:0] open_load;
		logic [7:0] over_current;
		logic supply_low;
		logic supply_high;
		logic thermal_shutdown;
		logic thermal_prewarning;
	} sdsp_fault_ev_t;

	// Control register write towards the power stage
	typedef struct packed {
		logic valid;
		logic [3:0] addr;
		logic [7:0] data;
	} sdsp_ctrl_wr_t;

endpackage

/* sdsp_ctrl_mem.sv */
// Control register storage with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "sdsp_params.svh"

module sdsp_ctrl_mem (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [3:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [3:0] rd_addr,
	output logic [7:0] rd_data_ff
);
	logic [7:0] entry_ff [0:15];
	logic [7:0] nxt_rd_data;

	// Each entry resets to a known value so the outputs start from a defined state
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_entry
			logic [7:0] nxt_entry;
			always_comb
			begin
				nxt_entry = entry_ff[gi];
				if (wr_en && (wr_addr == 4'(gi)))
					nxt_entry = wr_data;
			end
			always_ff @(posedge sys_clk or negedge reset_n)
			begin
				if (!reset_n)
					entry_ff[gi] <= `SDSP_CTRL_RESET;
				else
					entry_ff[gi] <= nxt_entry;
			end
		end
	endgenerate

	// Read port
	always_comb
	begin
		nxt_rd_data = entry_ff[rd_addr];
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			rd_data_ff <= `SDSP_CTRL_RESET;
		else
			rd_data_ff <= nxt_rd_data;
	end
endmodule // sdsp_ctrl_mem
`default_nettype wire

/* sdsp_spi_master.sv */
// Behavioural SPI master facing the diagnostic port
`timescale 1ns/10ps
`default_nettype none

module sdsp_spi_master (
	input wire logic sys_clk,
	input wire logic sdo_line,
	output logic sclk,
	output logic chip_select_n,
	output logic sdi
);
	// Half period in ns; raised by the bench for a slow transfer
	int half = 40;

	// Link parked: clock still and low, deselected, data low
	initial
	begin
		sclk = 1'b0;
		chip_select_n = 1'b1;
		sdi = 1'b0;
	end

	// Frame of nclk clocks, LSB first; pol[0] or pol[1] leaves the clock high at chip select fall or rise
	task automatic frame(input int nclk, input logic [31:0] tx, input logic [1:0] pol, output logic pre,
		output logic [31:0] rx);
		rx = 32'h0000_0000;
		@(negedge sys_clk);
		sclk = pol[0];
		#40;
		chip_select_n = 1'b0;
		sdi = 1'b0;
		#40;
		sclk = 1'b0;
		#40;
		pre = sdo_line;
		for (int k = 0; k < nclk; k++)
		begin
			// Data moves with the rising edge; sampled late because the port answers a few cycles after it
			sclk = 1'b1;
			sdi = tx[k];
			#(half);
			sclk = 1'b0;
			#(half - 10);
			rx[k] = sdo_line;
			#10;
		end
		sclk = pol[1];
		#40;
		chip_select_n = 1'b1;
		#40;
		sclk = 1'b0;
		sdi = 1'b0;
		#80;
	endtask
endmodule // sdsp_spi_master

`default_nettype wire

/* spi_diag_slave_port_tb.sv */
// Self-checking bench for the diagnostic SPI slave port
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin fail_count++; \
	$display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module spi_diag_slave_port_tb;
	import sdsp_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic enable = 1'b1;
	sdsp_fault_ev_t fault_ev = '0;
	wire logic sclk;
	wire logic chip_select_n;
	wire logic sdi;
	wire logic sdo_line;
	logic sdo;
	logic sdo_oe;
	sdsp_ctrl_wr_t ctrl_wr;
	sdsp_ctrl_wr_t last_wr;
	sdsp_gstat_t gstat;
	int fail_count = 0;
	int checked = 0;
	int wr_pulses = 0;
	int wr_in_frame = 0;
	int oe_cycles = 0;
	logic pre;
	logic [31:0] rx;
	logic sdo_hold = 1'b1;

	// Released line has no pull-up: it shows the inverse of the last driven bit, so a missing drive is seen
	assign sdo_line = sdo_oe ? sdo : ~sdo_hold;

	always #5 sys_clk = ~sys_clk;

	spi_diag_slave_port u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .sclk(sclk), .chip_select_n(chip_select_n),
		.sdi(sdi), .enable(enable), .fault_ev(fault_ev), .sdo(sdo), .sdo_oe(sdo_oe), .ctrl_wr(ctrl_wr),
		.gstat(gstat));

	sdsp_spi_master u_master (.sys_clk(sys_clk), .sdo_line(sdo_line), .sclk(sclk),
		.chip_select_n(chip_select_n), .sdi(sdi));

	// Control write strobes and drive activity, counted for later checks
	always @(negedge sys_clk)
	begin
		if (ctrl_wr.valid === 1'b1)
		begin
			wr_pulses++;
			last_wr = ctrl_wr;
			if (chip_select_n === 1'b0)
				wr_in_frame++;
		end
		if (sdo_oe === 1'b1)
		begin
			oe_cycles++;
			sdo_hold = sdo;
		end
	end

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Address byte then data byte, optionally of another clock count or with a clock fault
	task automatic xfer(input logic [7:0] ad, input logic [7:0] dt, input int nclk = 16,
		input logic [1:0] pol = 2'b00);
		u_master.frame(nclk, {16'h0000, dt, ad}, pol, pre, rx);
	endtask

	// Zero-clock frame: only the fault flag shows on the line
	task automatic zero_clk(input logic flag);
		u_master.frame(0, 32'h0000_0000, 2'b00, pre, rx);
		`CHK("flag", flag, pre)
		`CHK("no error", 1'b0, gstat.spi_err_bit)
		`CHK("sdo_oe released", 1'b0, sdo_oe)
	endtask

	// Frames before the set time are ignored
	task automatic t_wait();
		`CHK("summary at reset", 8'h00, gstat)
		xfer(8'h8F, 8'h5B);
		`CHK("drive in wait", 0, oe_cycles)
		`CHK("write in wait", 0, wr_pulses)
		repeat (1000) @(negedge sys_clk);
	endtask

	// Summary read-and-clear straight after reset
	task automatic t_summary();
		zero_clk(1'b1);
		xfer(8'hC3, 8'h01);
		`CHK("summary bits", 8'h00, rx[7:0])
		`CHK("summary reply", 8'h00, rx[15:8])
		`CHK("summary cleared", 8'h08, gstat)
		zero_clk(1'b0);
	endtask

	// Control write lands at chip select rise; read-back runs on a slow clock
	task automatic t_ctrl();
		xfer(8'h8F, 8'hA5);
		`CHK("write count", 1, wr_pulses)
		`CHK("write in frame", 0, wr_in_frame)
		`CHK("write addr", 4'h3, last_wr.addr)
		`CHK("write data", 8'hA5, last_wr.data)
		u_master.half = 200;
		xfer(8'h0F, 8'h01);
		u_master.half = 40;
		`CHK("read back", 8'hA5, rx[15:8])
		`CHK("read only", 1, wr_pulses)
	endtask

	// Enable low restarts the set time; a write inside it must be ignored
	task automatic t_enable();
		int oe0;
		oe0 = oe_cycles;
		@(negedge sys_clk);
		enable = 1'b0;
		repeat (10) @(negedge sys_clk);
		enable = 1'b1;
		xfer(8'h8F, 8'h5A);
		`CHK("drive after enable", oe0, oe_cycles)
		`CHK("write after enable", 1, wr_pulses)
		repeat (1000) @(negedge sys_clk);
		xfer(8'h0F, 8'h01);
		`CHK("register kept", 8'hA5, rx[15:8])
	endtask

	// Each malformed frame raises the protocol error, carried by the next summary
	task automatic t_proto();
		logic [7:0] ad [7] = '{8'h0F, 8'h0F, 8'h0E, 8'h0D, 8'h7F, 8'h0F, 8'h0F};
		int nc [7] = '{8, 24, 16, 16, 16, 16, 16};
		logic [1:0] pl [7] = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b01, 2'b10};
		logic er [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
		for (int i = 0; i < 7; i++)
		begin
			xfer(ad[i], 8'h01, nc[i], pl[i]);
			`CHK("error bit", er[i], gstat.spi_err_bit)
			xfer(8'hC3, 8'h01);
			`CHK("error in summary", er[i], rx[7])
			`CHK("error cleared", 8'h08, gstat)
		end
	endtask

	// Each fault source latches its summary bit until the master clears it
	task automatic t_faults();
		int src [6] = '{0, 1, 2, 3, 14, 9};
		logic [7:0] ex [6] = '{8'h0A, 8'h0C, 8'h18, 8'h28, 8'h48, 8'h48};
		for (int i = 0; i < 6; i++)
		begin
			@(negedge sys_clk);
			fault_ev = 20'(1) << src[i];
			@(negedge sys_clk);
			fault_ev = '0;
			repeat (5) @(negedge sys_clk);
			`CHK("fault summary", ex[i], gstat)
			zero_clk(1'b1);
			repeat (300) @(negedge sys_clk);
			`CHK("fault held", ex[i], gstat)
			xfer(8'hC7, 8'h01);
			`CHK("open load reply", (src[i] == 14) ? 8'h04 : 8'h00, rx[15:8])
			xfer(8'hCB, 8'h01);
			`CHK("overcurrent reply", (src[i] == 9) ? 8'h20 : 8'h00, rx[15:8])
			xfer(8'hC3, 8'h01);
			`CHK("fault cleared", 8'h08, gstat)
		end
	endtask

	// A fault arriving during the data byte of its own clear must survive
	task automatic t_race();
		fork
			xfer(8'hC7, 8'h01);
			begin
				repeat (100) @(negedge sys_clk);
				fault_ev.open_load[0] = 1'b1;
				@(negedge sys_clk);
				fault_ev.open_load[0] = 1'b0;
			end
		join
		xfer(8'h47, 8'h01);
		`CHK("fault kept", 8'h01, rx[15:8])
		xfer(8'hC7, 8'h01);
		xfer(8'hC3, 8'h01);
		`CHK("race cleared", 8'h08, gstat)
	endtask

	// Main sequence: reset for six cycles, then every scenario
	initial
	begin
		repeat (6) @(negedge sys_clk);
		reset_n = 1'b1;
		t_wait();
		t_summary();
		t_ctrl();
		t_enable();
		t_proto();
		t_faults();
		t_race();
		print_verdict();
	end

	// Watchdog: a hung run counts as a mismatch
	initial
	begin
		repeat (90000) @(posedge sys_clk);
		fail_count++;
		print_verdict();
	end
endmodule // spi_diag_slave_port_tb

`default_nettype wire
